// *** logic/beh_bus_err_handler.v ***
`timescale 1ns/1ps
`include "beh_defines.vh"
module beh_bus_err_handler
#(
  parameter N = 4,
  parameter W = 8,
  parameter HOLD_CYCLES = `BEH_HOLD_CYCLES
)
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output wire [1:0] s_bresp,
  output wire s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0] s_rresp,
  output wire s_rvalid,
  input wire s_rready,
  input wire bus_cycle_tick,
  input wire [N-1:0] xchg_ok,
  input wire [N-1:0] xchg_disturbed,
  input wire [N*W-1:0] mod_in_data,
  output reg xchg_enable_q,
  output reg bus_reconfig_q,
  output reg [N*W-1:0] mod_out_data_q,
  output reg irq_q
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  reg wr_hit;
  reg rd_hit;
  reg [31:0] rd_data;
  reg bus_error_policy_select_q;
  reg bus_restart_request_q;
  reg restart_prev_q;
  reg bus_off_q;
  reg [`BEH_IRQ_W-1:0] irq_stat_q;
  reg [`BEH_IRQ_W-1:0] irq_mask_q;
  reg [`BEH_IRQ_W-1:0] irq_ev;
  reg [N*W-1:0] out_img_q;
  reg [N*W-1:0] in_img_q;
  reg [N-1:0] fault_prev_q;
  reg [N-1:0] exp_prev_q;
  wire [N-1:0] module_link_state;
  wire [N-1:0] lost;
  wire [N-1:0] hold_exp;
  wire passive;
  wire tick;
  wire any_fault;
  wire [1:0] system_fault_word;
  wire restart_go;
  integer i;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // index of a per-module word window, or 8'hff when outside
  function [7:0] win_idx;
    input [7:0] addr;
    input [7:0] base;
    begin
      if (addr >= base && addr < base + 8'h20 && addr[1:0] == 2'h0)
        win_idx = (addr - base) >> 2;
      else
        win_idx = 8'hff;
    end
  endfunction

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  beh_axil_slave u_axil
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ----------------------------------------
  // status terms
  // ----------------------------------------
  assign passive = bus_error_policy_select_q == `BEH_POLICY_PASSIVE;
  // passive never stops the bus; bus off only comes from active policy
  assign tick = bus_cycle_tick && xchg_enable_q;
  assign any_fault = |module_link_state;
  // both low while the expansion bus is in error
  assign system_fault_word = {2{~any_fault}};
  // all three conditions, else the request is ignored
  assign restart_go = bus_restart_request_q && !restart_prev_q && !passive
    && system_fault_word == 2'h0 && any_fault;

  // ----------------------------------------
  // per-module supervisors
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_mod
      beh_mod_sup #(.HOLD_CYCLES(HOLD_CYCLES)) u_sup
      (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .ok(xchg_ok[g]),
        // active policy flags only the module that failed
        .disturbed(xchg_disturbed[g] & passive),
        .passive(passive),
        .restart(restart_go),
        .fault_q(module_link_state[g]),
        .lost_q(lost[g]),
        .hold_exp_q(hold_exp[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // control registers and bus state
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_error_policy_select_q <= `BEH_POLICY_ACTIVE;
      bus_restart_request_q <= 1'b0;
      restart_prev_q <= 1'b0;
      irq_mask_q <= {`BEH_IRQ_W{1'b0}};
      bus_off_q <= 1'b0;
      xchg_enable_q <= 1'b1;
      bus_reconfig_q <= 1'b0;
    end
    else
    begin
      restart_prev_q <= bus_restart_request_q;
      if (wr_en && wr_strb[0] && wr_addr == `BEH_CTRL_OFS)
      begin
        bus_error_policy_select_q <= wr_data[`BEH_CTRL_POLICY];
        bus_restart_request_q <= wr_data[`BEH_CTRL_RESTART];
      end
      if (wr_en && wr_strb[0] && wr_addr == `BEH_IRQ_MASK_OFS)
        irq_mask_q <= wr_data[`BEH_IRQ_W-1:0];
      // a module declared lost under active policy turns the bus off
      if (!passive && any_fault)
        bus_off_q <= 1'b1;
      if (restart_go)
        bus_off_q <= 1'b0;
      xchg_enable_q <= !(bus_off_q || (!passive && any_fault)) || restart_go;
      bus_reconfig_q <= restart_go;
    end
  end

  // ----------------------------------------
  // images and module outputs
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_img_q <= {N*W{1'b0}};
      in_img_q <= {N*W{1'b0}};
      mod_out_data_q <= {N*W{1'b0}};
    end
    else
    begin
      for (i = 0; i < N; i = i + 1)
      begin
        // output image takes application writes unless the bus is off
        if (wr_en && wr_strb[0] && win_idx(wr_addr, `BEH_OUTIMG_OFS) == i)
          out_img_q[i*W +: W] <= wr_data[W-1:0];
        // input image freezes while the module does not answer
        if (tick && xchg_ok[i])
          in_img_q[i*W +: W] <= mod_in_data[i*W +: W];
        // disturbed modules still get the application data
        if (bus_off_q || hold_exp[i])
          mod_out_data_q[i*W +: W] <= {W{1'b0}};
        else
          mod_out_data_q[i*W +: W] <= out_img_q[i*W +: W];
      end
      // bus off wipes both images
      if (bus_off_q)
      begin
        out_img_q <= {N*W{1'b0}};
        in_img_q <= {N*W{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------
  always @*
  begin
    irq_ev = {`BEH_IRQ_W{1'b0}};
    irq_ev[`BEH_IRQ_FAULT] = |(module_link_state & ~fault_prev_q);
    irq_ev[`BEH_IRQ_BUSOFF] = !passive && any_fault && !bus_off_q;
    irq_ev[`BEH_IRQ_HOLDEXP] = |(hold_exp & ~exp_prev_q);
    irq_ev[`BEH_IRQ_RESTART] = restart_go;
  end

  // set beats write-one-to-clear in the same cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= {`BEH_IRQ_W{1'b0}};
      fault_prev_q <= {N{1'b0}};
      exp_prev_q <= {N{1'b0}};
      irq_q <= 1'b0;
    end
    else
    begin
      fault_prev_q <= module_link_state;
      exp_prev_q <= hold_exp;
      if (wr_en && wr_strb[0] && wr_addr == `BEH_IRQ_STAT_OFS)
        irq_stat_q <= (irq_stat_q & ~wr_data[`BEH_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  always @*
  begin
    wr_hit = 1'b0;
    if (wr_addr == `BEH_CTRL_OFS)
      wr_hit = 1'b1;
    else if (wr_addr == `BEH_IRQ_STAT_OFS)
      wr_hit = 1'b1;
    else if (wr_addr == `BEH_IRQ_MASK_OFS)
      wr_hit = 1'b1;
    else if (win_idx(wr_addr, `BEH_OUTIMG_OFS) < N)
      wr_hit = 1'b1;
    else if (wr_addr == `BEH_STAT_OFS || wr_addr == `BEH_SYSF_OFS)
      wr_hit = 1'b1;
  end

  // ----------------------------------------
  // read decode; the application polls state here or is told through irq_q
  // ----------------------------------------
  always @*
  begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    if (s_araddr == `BEH_CTRL_OFS)
    begin
      rd_data[`BEH_CTRL_POLICY] = bus_error_policy_select_q;
      rd_data[`BEH_CTRL_RESTART] = bus_restart_request_q;
    end
    else if (s_araddr == `BEH_STAT_OFS)
    begin
      rd_data[`BEH_STAT_BUSOFF] = bus_off_q;
      rd_data[`BEH_STAT_MODS +: N] = module_link_state;
    end
    else if (s_araddr == `BEH_IRQ_STAT_OFS)
      rd_data[`BEH_IRQ_W-1:0] = irq_stat_q;
    else if (s_araddr == `BEH_IRQ_MASK_OFS)
      rd_data[`BEH_IRQ_W-1:0] = irq_mask_q;
    else if (s_araddr == `BEH_SYSF_OFS)
      rd_data[1:0] = system_fault_word;
    else if (win_idx(s_araddr, `BEH_OUTIMG_OFS) < N)
      rd_data[W-1:0] = out_img_q[win_idx(s_araddr, `BEH_OUTIMG_OFS)*W +: W];
    else if (win_idx(s_araddr, `BEH_INIMG_OFS) < N)
      rd_data[W-1:0] = in_img_q[win_idx(s_araddr, `BEH_INIMG_OFS)*W +: W];
    else
      rd_hit = 1'b0;
  end

  // the block never halts the controller: no output here gates the
  // application or embedded I/O, only expansion traffic
endmodule

// *** common/beh_defines.vh ***
`ifndef BEH_DEFINES_VH
`define BEH_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BEH_CTRL_OFS 8'h00
`define BEH_STAT_OFS 8'h04
`define BEH_IRQ_STAT_OFS 8'h08
`define BEH_IRQ_MASK_OFS 8'h0c
`define BEH_SYSF_OFS 8'h10
`define BEH_OUTIMG_OFS 8'h20
`define BEH_INIMG_OFS 8'h40
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define BEH_CTRL_POLICY 0
`define BEH_CTRL_RESTART 1
`define BEH_STAT_BUSOFF 0
`define BEH_STAT_MODS 8
`define BEH_POLICY_ACTIVE 1'b0
`define BEH_POLICY_PASSIVE 1'b1
`define BEH_STATE_HEALTHY 1'b0
`define BEH_STATE_FAULT 1'b1
`define BEH_FAIL_LIMIT 2'h2
`define BEH_IRQ_FAULT 0
`define BEH_IRQ_BUSOFF 1
`define BEH_IRQ_HOLDEXP 2
`define BEH_IRQ_RESTART 3
`define BEH_IRQ_W 4
// ----------------------------------------
// timing
// ----------------------------------------
`define BEH_CLK_HZ 10000000
`define BEH_HOLD_S 10
`define BEH_HOLD_CYCLES (`BEH_HOLD_S * `BEH_CLK_HZ)
`define BEH_RESP_OKAY 2'h0
`define BEH_RESP_SLVERR 2'h2
`endif

// *** logic/beh_axil_slave.v ***
`timescale 1ns/1ps
`include "beh_defines.vh"
module beh_axil_slave
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  output reg wr_en,
  output reg [7:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_hit,
  input wire [31:0] rd_data,
  input wire rd_hit
);
  reg aw_held_q;
  reg w_held_q;

  // ----------------------------------------
  // write path: address and data in either order
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= `BEH_RESP_OKAY;
    end
    else
    begin
      wr_en <= 1'b0;
      if (s_awvalid && s_awready)
      begin
        wr_addr <= s_awaddr;
        aw_held_q <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
        w_held_q <= 1'b1;
        s_wready <= 1'b0;
      end
      // both halves held: commit once, answer next edge
      if (aw_held_q && w_held_q && !s_bvalid && !wr_en)
        wr_en <= 1'b1;
      if (wr_en)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? `BEH_RESP_OKAY : `BEH_RESP_SLVERR;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read path: data captured at the address edge
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= `BEH_RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_data;
      s_rresp <= rd_hit ? `BEH_RESP_OKAY : `BEH_RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end
endmodule

// *** logic/beh_mod_sup.v ***
`timescale 1ns/1ps
`include "beh_defines.vh"
module beh_mod_sup
#(
  parameter HOLD_CYCLES = `BEH_HOLD_CYCLES
)
(
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire ok,
  input wire disturbed,
  input wire passive,
  input wire restart,
  output reg fault_q,
  output reg lost_q,
  output reg hold_exp_q
);
  reg [1:0] fail_q;
  reg [31:0] hold_q;

  // ----------------------------------------
  // per-module fail count, state and hold timer
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn || restart)
    begin
      fail_q <= 2'h0;
      fault_q <= `BEH_STATE_HEALTHY;
      lost_q <= 1'b0;
      hold_q <= 32'h0;
      hold_exp_q <= 1'b0;
    end
    else
    begin
      if (tick && ok)
      begin
        fail_q <= 2'h0;
        if (passive)
        begin
          // recovered module rejoins without restart
          lost_q <= 1'b0;
          hold_q <= 32'h0;
          hold_exp_q <= 1'b0;
          // disturbed but answering still counts as faulty
          fault_q <= disturbed;
        end
      end
      else if (tick)
      begin
        if (fail_q != `BEH_FAIL_LIMIT)
          fail_q <= fail_q + 2'h1;
        // declared after two failed cycles in a row
        if (fail_q + 2'h1 >= `BEH_FAIL_LIMIT)
        begin
          fault_q <= `BEH_STATE_FAULT;
          lost_q <= 1'b1;
        end
      end
      // hold timer runs while passive retries last
      if (passive && lost_q && !hold_exp_q)
      begin
        hold_q <= hold_q + 32'h1;
        if (hold_q >= HOLD_CYCLES - 1)
          hold_exp_q <= 1'b1;
      end
    end
  end
endmodule

// *** sim/beh_xmod_model.sv ***
`timescale 1ns/1ps
module beh_xmod_model
#(
  parameter N = 4,
  parameter W = 8
)
(
  input wire aclk,
  input wire aresetn,
  input wire [N-1:0] fail_mask,
  input wire [N-1:0] disturb_mask,
  input wire [N*W-1:0] val,
  output wire bus_cycle_tick,
  output wire [N-1:0] xchg_ok,
  output wire [N-1:0] xchg_disturbed,
  output wire [N*W-1:0] mod_in_data
);
  logic [1:0] div_q;
  logic [W-1:0] junk_q;
  // bus task cycle every fourth clock; junk moves every clock
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q <= 2'h0;
      junk_q <= '0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      junk_q <= junk_q + 8'h35;
    end
  end
  assign bus_cycle_tick = aresetn && (div_q == 2'h3);
  assign xchg_ok = ~fail_mask;
  assign xchg_disturbed = disturb_mask;
  // a silent module leaves no stale value on its data lines
  for (genvar i = 0; i < N; i++)
  begin : g_mod
    assign mod_in_data[i*W +: W] = fail_mask[i] ? junk_q : val[i*W +: W];
  end
endmodule

// *** sim/beh_bus_err_handler_monitor.sv ***
`timescale 1ns/1ps
module beh_bus_err_handler_monitor
#(
  parameter N = 4,
  parameter W = 8
)
(
  input wire aclk,
  input wire aresetn,
  input wire s_awvalid,
  input wire s_awready,
  input wire s_wvalid,
  input wire s_wready,
  input wire s_bvalid,
  input wire s_arvalid,
  input wire s_arready,
  input wire s_rvalid,
  input wire xchg_enable_q,
  input wire bus_reconfig_q,
  input wire [N*W-1:0] mod_out_data_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_off_held;
    !xchg_enable_q [*2];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_reset_vals: assert property ($rose(aresetn) |-> xchg_enable_q && !bus_reconfig_q && mod_out_data_q == '0)
    else $error("outputs wrong after reset");
  chk_off_zeroes: assert property (s_off_held |-> mod_out_data_q == '0)
    else $error("outputs driven while bus off");
  chk_off_prompt: assert property ($fell(xchg_enable_q) |-> ##[0:1] mod_out_data_q == '0)
    else $error("outputs not zeroed at bus off");
  chk_reconf_pulse: assert property (bus_reconfig_q |=> !bus_reconfig_q)
    else $error("restart pulse too long");
  chk_reconf_needs_off: assert property ($rose(bus_reconfig_q) |-> !$past(xchg_enable_q))
    else $error("restart while bus running");
  chk_reconf_resume: assert property (bus_reconfig_q |-> ##[0:2] xchg_enable_q)
    else $error("exchange not resumed after restart");
  chk_resume_cause: assert property ($rose(xchg_enable_q) |-> bus_reconfig_q || $past(bus_reconfig_q))
    else $error("bus came back without restart");
  chk_wr_latency: assert property (s_wr_taken |-> ##[2:3] s_bvalid)
    else $error("write response late");
  chk_rd_latency: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read data late");
endmodule
bind beh_bus_err_handler beh_bus_err_handler_monitor #(.N(N), .W(W)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rvalid(s_rvalid), .xchg_enable_q(xchg_enable_q),
  .bus_reconfig_q(bus_reconfig_q), .mod_out_data_q(mod_out_data_q));

// *** sim/beh_bus_err_handler_tb.sv ***
`timescale 1ns/1ps
`include "beh_defines.vh"
module beh_bus_err_handler_tb;
  localparam N = 4;
  localparam W = 8;
  localparam [7:0] a_ctrl = `BEH_CTRL_OFS;
  localparam [7:0] a_stat = `BEH_STAT_OFS;
  localparam [7:0] a_irq = `BEH_IRQ_STAT_OFS;
  localparam [7:0] a_mask = `BEH_IRQ_MASK_OFS;
  localparam [7:0] a_in = `BEH_INIMG_OFS;
  localparam [7:0] a_out = `BEH_OUTIMG_OFS;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, bus_cycle_tick, xchg_enable_q, bus_reconfig_q, irq_q;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic [N-1:0] xchg_ok, xchg_disturbed, fail_mask, disturb_mask;
  logic [N*W-1:0] mod_in_data, mod_out_data_q, val;
  int n_fail = 0;
  int comparisons = 0;
  int n_reconf = 0;
  // short hold so the expiry is reached quickly
  beh_bus_err_handler #(.N(N), .W(W), .HOLD_CYCLES(60)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .bus_cycle_tick(bus_cycle_tick), .xchg_ok(xchg_ok), .xchg_disturbed(xchg_disturbed),
    .mod_in_data(mod_in_data), .xchg_enable_q(xchg_enable_q), .bus_reconfig_q(bus_reconfig_q),
    .mod_out_data_q(mod_out_data_q), .irq_q(irq_q));
  beh_xmod_model #(.N(N), .W(W)) u_xmod (
    .aclk(aclk), .aresetn(aresetn), .fail_mask(fail_mask), .disturb_mask(disturb_mask), .val(val),
    .bus_cycle_tick(bus_cycle_tick), .xchg_ok(xchg_ok), .xchg_disturbed(xchg_disturbed),
    .mod_in_data(mod_in_data));
  // ----------------------------------------
  // clock, watchdog, restart counter
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    #3000000;
    n_fail++;
    summarize();
  end
  always @(posedge aclk)
    if (bus_reconfig_q === 1'b1) n_reconf++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // the edge on entry keeps two drives of one signal apart
  // no local limit: only the watchdog ends a wait for the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (s_bvalid !== 1'b1)
    begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
    chk("bresp", r, s_bresp);
  endtask
  task automatic axr(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (s_rvalid !== 1'b1)
    begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
    chk(nm, e, s_rdata);
    chk("rresp", r, s_rresp);
  endtask
  task automatic ticks(input int n);
    repeat (n * 4) @(posedge aclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    axr("ctrl", a_ctrl, 32'h0);
    axr("stat", a_stat, 32'h0);
    axr("sysf", `BEH_SYSF_OFS, 32'h3);
    axr("unmapped", 8'h80, 32'h0, `BEH_RESP_SLVERR);
    axw(8'h80, 32'h1, `BEH_RESP_SLVERR);
    // a write without the low strobe must leave the register alone
    s_wstrb <= 4'h0;
    axw(a_mask, 32'hf);
    s_wstrb <= 4'hf;
    axr("mask nostrb", a_mask, 32'h0);
  endtask
  task automatic t_active();
    axw(a_mask, 32'hf);
    axw(a_out, 32'h5a);
    ticks(2);
    chk("out0", 8'h5a, mod_out_data_q[7:0]);
    fail_mask <= 4'h1;
    ticks(1);
    fail_mask <= 4'h0;
    ticks(2);
    chk("enable one fail", 1'b1, xchg_enable_q);
    fail_mask <= 4'h1;
    ticks(4);
    chk("enable", 1'b0, xchg_enable_q);
    chk("out", 32'h0, mod_out_data_q);
    chk("irq", 1'b1, irq_q);
    axr("stat", a_stat, 32'h101);
    axr("outimg", a_out, 32'h0);
    axr("inimg", a_in, 32'h0);
    axr("sysf", `BEH_SYSF_OFS, 32'h0);
    axw(a_mask, 32'h0);
    axr("irqst", a_irq, 32'h3);
    chk("irq masked", 1'b0, irq_q);
    axw(a_irq, 32'h3);
    axr("irqst clr", a_irq, 32'h0);
    axw(a_mask, 32'hf);
  endtask
  // policy checked first, then the edge of the stored bit
  task automatic t_restart();
    axw(a_ctrl, 32'h1);
    axw(a_ctrl, 32'h3);
    ticks(1);
    chk("restart passive", 0, n_reconf);
    chk("enable", 1'b0, xchg_enable_q);
    fail_mask <= 4'h0;
    axw(a_ctrl, 32'h2);
    chk("restart no edge", 0, n_reconf);
    axw(a_ctrl, 32'h0);
    axw(a_ctrl, 32'h2);
    ticks(1);
    chk("restart", 1, n_reconf);
    chk("enable", 1'b1, xchg_enable_q);
    axr("stat", a_stat, 32'h0);
    axr("irqst", a_irq, 32'h8);
    axw(a_irq, 32'h8);
    axw(a_ctrl, 32'h0);
    axw(a_ctrl, 32'h2);
    ticks(1);
    chk("restart no fault", 1, n_reconf);
    axw(a_ctrl, 32'h0);
  endtask
  task automatic t_passive();
    axw(a_ctrl, 32'h1);
    val <= 32'h00003300;
    axw(a_out + 8'h04, 32'h77);
    axw(a_out + 8'h08, 32'h99);
    ticks(2);
    axr("in1", a_in + 8'h04, 32'h33);
    fail_mask <= 4'h2;
    disturb_mask <= 4'h4;
    val <= 32'h00004400;
    ticks(3);
    chk("out1 held", 8'h77, mod_out_data_q[15:8]);
    chk("enable", 1'b1, xchg_enable_q);
    chk("out2", 8'h99, mod_out_data_q[23:16]);
    axr("stat", a_stat, 32'h600);
    axr("in1 frozen", a_in + 8'h04, 32'h33);
    axw(a_out + 8'h04, 32'h78);
    axr("outimg1", a_out + 8'h04, 32'h78);
    ticks(20);
    chk("out1 zero", 8'h0, mod_out_data_q[15:8]);
    chk("out2", 8'h99, mod_out_data_q[23:16]);
    axr("irqst", a_irq, 32'h5);
    fail_mask <= 4'h0;
    disturb_mask <= 4'h0;
    ticks(3);
    axr("stat", a_stat, 32'h0);
    axr("in1", a_in + 8'h04, 32'h44);
    chk("out1", 8'h78, mod_out_data_q[15:8]);
    chk("no restart", 1, n_reconf);
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    aresetn = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
    {s_awaddr, s_araddr, s_wdata} = 48'h0;
    s_wstrb = 4'hf;
    {fail_mask, disturb_mask, val} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_active();
    t_restart();
    t_passive();
    summarize();
  end
endmodule
